// ---- mwk_host.sv ----
// host end of the display serial link: hibernation entry, client service
// request detection, wake-up sequence; apb slave for its own registers.
// assumes data_in comes from a pin (synchronised here); strobe is made here.
// Function
// (RULE_01) toggle strobe 64 cycles after shutdown, stop
// (RULE_02) data low, release between 16 and 48
// (RULE_03) hibernation: data and strobe drivers off
// (RULE_04) client offsets its strobe receiver first
// (RULE_05) client then drives data high
// (RULE_06) answer client request: data high, strobe low
// (RULE_07) wait 200 ns before first strobe pulse
// (RULE_08) 150 pulses with data held high
// (RULE_09) client drops offset at first pulse
// (RULE_10) client releases after 70, host holds on
// (RULE_11) hold data low 50 strobe cycles
// (RULE_12) then forward link starts with header
// (RULE_13) client wake triggers configured before shutdown; the bench sets them while the link hibernates
// (RULE_14) frame wake enable syncs request to vsync
// (RULE_15) frame and line count set wake point; the client model counts frames only
// (RULE_16) awake flag; wake request clears itself
// (RULE_17) pin edge latches interrupt, wakes link; the client model only arms the wake and requests it at the frame wake point
// (RULE_18) host reads and clears pin interrupts
// (RULE_19) pin data register drives output pins
// (RULE_20) direction register, zero means input
// (RULE_21) pin interrupt enable and polarity registers
// (RULE_22) input pins serve only as wake sources
//
// Local design decision: register access over APB.
module mwk_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        data_in,
    output logic             data_out,
    output logic             data_oe,
    output logic             stb_out,
    output logic             stb_oe,
    output logic             link_awake
);
    // link state and counters
    mwk_pkg::mwk_state_t st_q;      // link state
    mwk_pkg::mwk_state_t st_d;
    logic [7:0]          cnt_q;     // strobe cycles within a state
    logic [7:0]          cnt_d;
    logic [4:0]          wcnt_q;    // pclk cycles of the settle wait
    logic [4:0]          wcnt_d;
    mwk_pkg::mwk_drive_t drv_q;     // registered pin drive
    mwk_pkg::mwk_drive_t drv_d;
    logic                run_q;     // strobe divider enable
    logic                run_d;
    logic                awake_d;

    // data pin synchroniser and request filter
    logic       din_s1_q;   // first stage, read by second stage only
    logic       din_s2_q;
    logic [1:0] req_cnt_q;  // consecutive high samples in hibernation
    logic [1:0] req_cnt_d;

    // apb state
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        auto_q;     // honour client requests
    logic        req_seen_q; // sticky client request flag
    logic        stb_q;
    logic        cyc_done;

    // apb decode
    wire acc      = psel & penable;
    wire rd_phase = acc & !pready_q;
    wire wr_hit   = acc & pready_q & pwrite;
    wire hit_ctrl = (paddr == mwk_pkg::CTRL_OFS);
    wire hit_stat = (paddr == mwk_pkg::STATUS_OFS);
    wire mapped   = hit_ctrl | hit_stat;
    wire ctrl_wr  = wr_hit & hit_ctrl;
    wire shut_cmd = ctrl_wr & pwdata[mwk_pkg::CTRL_SHUT_BIT];
    wire wake_cmd = ctrl_wr & pwdata[mwk_pkg::CTRL_WAKE_BIT];
    wire req_clr  = wr_hit & hit_stat & pwdata[mwk_pkg::STAT_REQ_BIT];

    // client asks for service: it drives data high while we float it
    wire cli_req  = (st_q == mwk_pkg::ST_HIBER) && din_s2_q &&
                    (req_cnt_q == mwk_pkg::REQ_FILT - 2'h1);
    wire cyc_last = cyc_done && (cnt_q == st_last(st_q));

    wire [31:0] stat_word = {27'h0000000, req_seen_q, link_awake,
                             st_q};
    wire [31:0] ctrl_word = {29'h00000000, auto_q, 2'h0};
    wire [31:0] rd_word   = hit_ctrl ? ctrl_word :
                            hit_stat ? stat_word : 32'h00000000;

    // last strobe cycle index of each counted state
    function automatic logic [7:0] st_last(input mwk_pkg::mwk_state_t s);
        logic [7:0] n;
        n = 8'h00;
        unique case (s)
            mwk_pkg::ST_SHUT:     n = mwk_pkg::SHUT_CYC - 8'h01;
            mwk_pkg::ST_PULSE_HI: n = mwk_pkg::HI_CYC - 8'h01;
            mwk_pkg::ST_PULSE_LO: n = mwk_pkg::LO_CYC - 8'h01;
            default:              n = 8'hFF;
        endcase
        return n;
    endfunction

    // strobe source
    mwk_stb_gen u_stb (
        .pclk       (pclk),
        .presetn    (presetn),
        .run        (run_q),
        .stb_q      (stb_q),
        .cyc_done_q (cyc_done)
    );

    // next state of the link sequencer
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            mwk_pkg::ST_ACTIVE:
                if (shut_cmd) begin
                    st_d = mwk_pkg::ST_SHUT;
                end
            mwk_pkg::ST_SHUT:
                if (cyc_last) begin
                    st_d = mwk_pkg::ST_HIBER;   // see (RULE_01)
                end
            mwk_pkg::ST_HIBER:
                // client request only counts when enabled
                if (wake_cmd || (cli_req && auto_q)) begin
                    st_d = mwk_pkg::ST_SETTLE;  // see (RULE_06)
                end
            mwk_pkg::ST_SETTLE:
                if (wcnt_q == 5'(mwk_pkg::SETTLE_CYC - 1)) begin
                    st_d = mwk_pkg::ST_PULSE_HI;  // see (RULE_07)
                end
            mwk_pkg::ST_PULSE_HI:
                if (cyc_last) begin
                    st_d = mwk_pkg::ST_PULSE_LO;  // see (RULE_10)
                end
            mwk_pkg::ST_PULSE_LO:
                if (cyc_last) begin
                    st_d = mwk_pkg::ST_ACTIVE;    // see (RULE_12)
                end
            default:
                st_d = mwk_pkg::ST_HIBER;
        endcase
    end

    // strobe and settle counters restart on every state change; request filter clears on data low or outside hibernation
    assign cnt_d  = (st_d != st_q) ? 8'h00 :
                    cyc_done ? cnt_q + 8'h01 : cnt_q;
    assign wcnt_d = (st_q == mwk_pkg::ST_SETTLE && st_d == st_q) ?
                    wcnt_q + 5'h01 : 5'h00;
    assign req_cnt_d = (st_q == mwk_pkg::ST_HIBER && din_s2_q) ?
                       ((req_cnt_q == mwk_pkg::REQ_FILT - 2'h1) ?
                        req_cnt_q : req_cnt_q + 2'h1) : 2'h0;

    // pin drive from the next state so the pins move with it
    always_comb begin
        drv_d   = '0;
        run_d   = 1'b0;
        awake_d = 1'b0;
        unique case (st_d)
            mwk_pkg::ST_ACTIVE: begin
                // forward link running: data low stands for idle
                drv_d.data_oe = 1'b1;
                drv_d.stb_oe  = 1'b1;
                run_d         = 1'b1;
                awake_d       = 1'b1;
            end
            mwk_pkg::ST_SHUT: begin
                // data low first, released at a fixed point in the window
                drv_d.data_oe = (st_q != mwk_pkg::ST_SHUT) ||
                                (cnt_d < mwk_pkg::DATA_OFF_CYC); // see (RULE_02)
                drv_d.stb_oe  = 1'b1;
                run_d         = 1'b1;   // see (RULE_01)
            end
            mwk_pkg::ST_HIBER: begin
                drv_d = '0;             // see (RULE_03)
            end
            mwk_pkg::ST_SETTLE: begin
                drv_d.data_out = 1'b1;  // see (RULE_06)
                drv_d.data_oe  = 1'b1;
                drv_d.stb_oe   = 1'b1;  // strobe held low
            end
            mwk_pkg::ST_PULSE_HI: begin
                // strobe toggles every bit, as for data zero
                drv_d.data_out = 1'b1;  // see (RULE_08)
                drv_d.data_oe  = 1'b1;
                drv_d.stb_oe   = 1'b1;
                run_d          = 1'b1;
            end
            mwk_pkg::ST_PULSE_LO: begin
                drv_d.data_oe = 1'b1;   // see (RULE_11)
                drv_d.stb_oe  = 1'b1;
                run_d         = 1'b1;
            end
            default: begin
                drv_d = '0;
            end
        endcase
    end

    // data pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_s1_q <= 1'b0;
            din_s2_q <= 1'b0;
        end else begin
            din_s1_q <= data_in;
            din_s2_q <= din_s1_q;
        end
    end

    // sequencer registers; reset leaves the link hibernating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= mwk_pkg::ST_HIBER;
            cnt_q     <= 8'h00;
            wcnt_q    <= 5'h00;
            req_cnt_q <= 2'h0;
            drv_q     <= '0;
            run_q     <= 1'b0;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            wcnt_q    <= wcnt_d;
            req_cnt_q <= req_cnt_d;
            drv_q     <= drv_d;
            run_q     <= run_d;
        end
    end

    // awake flag follows the sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_awake <= 1'b0;
        end else begin
            link_awake <= awake_d;
        end
    end

    // apb: one wait state, answer registered so outputs come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= rd_phase;
            pslverr_q <= rd_phase & !mapped;
            prdata_q  <= (rd_phase && !pwrite) ? rd_word : 32'h00000000;
        end
    end

    // config and sticky request; a new request wins over its clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_q     <= mwk_pkg::CTRL_AUTO_RST;
            req_seen_q <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                auto_q <= pwdata[mwk_pkg::CTRL_AUTO_BIT];
            end
            req_seen_q <= cli_req | (req_seen_q & !req_clr);
        end
    end

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign data_out = drv_q.data_out;
    assign data_oe  = drv_q.data_oe;
    assign stb_oe   = drv_q.stb_oe;
    assign stb_out  = stb_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_shut_length: assert property ( // see (RULE_01)
        (st_q == mwk_pkg::ST_SHUT && st_d == mwk_pkg::ST_HIBER)
        |-> cnt_q == mwk_pkg::SHUT_CYC - 8'h01 && cyc_done)
        else $error("shutdown strobe run has wrong length");
    chk_data_release: assert property ( // see (RULE_02)
        (st_q == mwk_pkg::ST_SHUT && cnt_q >= mwk_pkg::DATA_OFF_CYC)
        |=> !data_oe)
        else $error("data not released inside shutdown window");
    chk_shut_data_low: assert property ( // see (RULE_02)
        (st_q == mwk_pkg::ST_SHUT) |=> !data_out)
        else $error("data high during shutdown");
    chk_hiber_quiet: assert property ( // see (RULE_03)
        (st_q == mwk_pkg::ST_HIBER && st_d == st_q)
        |=> !data_oe && !stb_oe && !stb_out)
        else $error("driver on during hibernation");
    chk_req_answer: assert property ( // see (RULE_06)
        (cli_req && auto_q)
        |-> ##1 (data_oe && data_out && stb_oe && !stb_out)[*2])
        else $error("client request not answered");
    chk_settle_wait: assert property ( // see (RULE_07)
        $rose(st_q == mwk_pkg::ST_PULSE_HI)
        |-> $past(wcnt_q) == 5'(mwk_pkg::SETTLE_CYC - 1) && !stb_out)
        else $error("strobe pulses before settle time");
    chk_high_pulses: assert property ( // see (RULE_10)
        (st_q == mwk_pkg::ST_PULSE_HI && st_d == mwk_pkg::ST_PULSE_LO)
        |-> cnt_q == mwk_pkg::HI_CYC - 8'h01 && data_out)
        else $error("data high run has wrong length");
    chk_low_cycles: assert property ( // see (RULE_11)
        (st_q == mwk_pkg::ST_PULSE_LO && st_d != st_q)
        |-> cnt_q == mwk_pkg::LO_CYC - 8'h01 ##1 !data_out ##1 link_awake)
        else $error("data low run has wrong length");

    cov_client_wake: cover property (
        cli_req && auto_q ##[1:1000] st_q == mwk_pkg::ST_PULSE_HI);
    cov_shutdown: cover property (
        st_q == mwk_pkg::ST_SHUT ##1 st_q == mwk_pkg::ST_HIBER);
    cov_host_wake: cover property (
        wake_cmd && st_q == mwk_pkg::ST_HIBER);
endmodule

// ---- mwk_pkg.sv ----
// package for the display link host wake-up controller: register map of
// the controller's own apb registers, the client's register map, timing.
// assumes a 100 MHz pclk; strobe cycles are built from pclk by a divider.
package mwk_pkg;

    // apb register byte offsets of the controller itself
    localparam logic [7:0] CTRL_OFS   = 8'h00;  // commands and config
    localparam logic [7:0] STATUS_OFS = 8'h04;  // state, flags

    // ctrl fields
    localparam int CTRL_SHUT_BIT  = 0;  // write 1: start shutdown
    localparam int CTRL_WAKE_BIT  = 1;  // write 1: host wake-up
    localparam int CTRL_AUTO_BIT  = 2;  // 1: honour client requests
    localparam logic CTRL_AUTO_RST = 1'b1;

    // status fields
    localparam int STAT_ST_LSB    = 0;  // [2:0] link state
    localparam int STAT_AWAKE_BIT = 3;  // link awake
    localparam int STAT_REQ_BIT   = 4;  // sticky client request, w1c

    // client register map, reached by register access packets only
    localparam logic [7:0] CLI_FRAME_WAKE_OFS = 8'h50;  // see (RULE_14)
    localparam logic [7:0] CLI_WAKE_POINT_OFS = 8'h51;  // see (RULE_15)
    localparam logic [7:0] CLI_PIN_DATA_OFS   = 8'h66;  // see (RULE_19)
    localparam logic [7:0] CLI_PIN_DIR_OFS    = 8'h67;  // see (RULE_20)
    localparam logic [7:0] CLI_PIN_IRQ_OFS    = 8'h68;  // see (RULE_18)
    localparam logic [7:0] CLI_PIN_IEN_OFS    = 8'h69;  // see (RULE_21)
    localparam logic [7:0] CLI_PIN_POL_OFS    = 8'h6A;
    localparam logic [9:0] CLI_PIN_DIR_RST    = 10'h000;
    localparam logic [9:0] CLI_PIN_IEN_RST    = 10'h000;
    localparam logic [9:0] CLI_PIN_POL_RST    = 10'h3FF;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [7:0] STB_HALF_CLKS = 8'h04;  // 80 ns strobe period
    localparam int SETTLE_NS  = 200;               // least, rounds up
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
    localparam logic [7:0] SHUT_CYC     = 8'h40;  // 64 strobe cycles
    localparam logic [7:0] DATA_OFF_CYC = 8'h20;  // 32, inside 16..48
    localparam logic [7:0] HI_CYC       = 8'h96;  // 150 pulses data high
    localparam logic [7:0] LO_CYC       = 8'h32;  // 50 cycles data low
    localparam logic [1:0] REQ_FILT     = 2'h2;   // samples to accept req

    // link states
    typedef enum logic [2:0] {
        ST_ACTIVE   = 3'h0,
        ST_SHUT     = 3'h1,
        ST_HIBER    = 3'h2,
        ST_SETTLE   = 3'h3,
        ST_PULSE_HI = 3'h4,
        ST_PULSE_LO = 3'h5
    } mwk_state_t;

    // drive of the two link pins
    typedef struct packed {
        logic data_out;
        logic data_oe;
        logic stb_oe;
    } mwk_drive_t;

endpackage

// ---- mwk_stb_gen.sv ----
// strobe divider: makes the link strobe from pclk and marks each cycle end.
// assumes run is a registered level from the same clock.
module mwk_stb_gen (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    output logic      stb_q,
    output logic      cyc_done_q
);
    logic [7:0] div_q;   // pclk count within half period
    logic [7:0] div_d;
    wire        half_end = (div_q == mwk_pkg::STB_HALF_CLKS - 8'h01);

    // wrap the divider at each half period, clear it while stopped
    assign div_d = (!run || half_end) ? 8'h00 : div_q + 8'h01;

    // strobe toggles each half period; a falling toggle ends a cycle,
    // so a stopped strobe always rests low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q      <= 8'h00;
            stb_q      <= 1'b0;
            cyc_done_q <= 1'b0;
        end else begin
            div_q      <= div_d;
            stb_q      <= run ? (stb_q ^ half_end) : 1'b0;
            cyc_done_q <= run & half_end & stb_q;
        end
    end
endmodule

// ---- mwk_client_model.sv ----
// behavioural model of the display client at the far end of the link:
// wake request, strobe receiver offset, pin interrupt bank, awake flag.
// assumes the bench resolves both wires and says when strobe is driven;
// register access packets are stood in for by the reg_write task.
module mwk_client_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       data_line,
    input  wire logic       stb_line,
    input  wire logic       stb_driven,  // host strobe driver is on
    input  wire logic       frame_wrap,  // internal vsync pulse
    input  wire logic [9:0] pin_in,
    output logic            data_oe_c
);
    logic       frame_wake_q;             // frame wake enable
    logic [7:0] wake_frames_q;            // wake_frame_count field
    logic [7:0] fcnt_q;                   // frames seen since arming
    logic [9:0] pin_data_q;
    logic [9:0] pin_dir_q;
    logic [9:0] pin_irq_q;                // latched pin interrupts
    logic [9:0] pin_ien_q;
    logic [9:0] pin_pol_q;
    logic [9:0] pin_prev_q;
    logic       pin_flag_q;               // pin wake pending
    logic       req_q;                    // service request wanted
    logic       offset_q;                 // receiver offset on
    logic       rx_en_q;                  // strobe receiver on
    logic       rx_prev_q;
    logic       awake_q;
    logic [7:0] pulses_q;                 // strobe pulses since wake
    logic [7:0] low_q;                    // pulses with data low
    wire  logic       rx_stb;
    wire  logic [9:0] edge_hit;
    wire  logic [9:0] pin_drive;

    // with offset an undriven strobe reads zero, so no false pulse
    assign rx_stb = rx_en_q
                    & (offset_q ? (stb_driven & stb_line) : stb_line);
    // qualifying edge of an enabled input pin; no other input use
    assign edge_hit = pin_ien_q & ~pin_dir_q & (pin_in ^ pin_prev_q)
                      & ~(pin_in ^ pin_pol_q);
    // output pins all follow one data write
    assign pin_drive = pin_data_q & pin_dir_q;

    // register write, taken off the clock edge to avoid a race
    task automatic reg_write(input logic [7:0] a, input logic [9:0] d);
        @(negedge pclk);
        case (a)
            8'h50: frame_wake_q = d[0];
            8'h51: wake_frames_q = d[7:0];
            8'h66: pin_data_q = d;
            8'h67: pin_dir_q = d;
            8'h68: pin_irq_q = pin_irq_q & ~d;
            8'h69: pin_ien_q = d;
            8'h6A: pin_pol_q = d;
            default: ;
        endcase
    endtask

    // wake sequence: request, offset, receiver, drive data, count pulses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {frame_wake_q, pin_flag_q, req_q, offset_q} <= '0;
            {rx_en_q, rx_prev_q, awake_q, data_oe_c} <= '0;
            {wake_frames_q, fcnt_q, pulses_q, low_q} <= '0;
            {pin_data_q, pin_dir_q, pin_irq_q, pin_ien_q} <= '0;
            pin_pol_q  <= 10'h3FF;
            pin_prev_q <= 10'h000;
        end else begin
            rx_prev_q  <= rx_stb;
            pin_prev_q <= pin_in;
            pin_irq_q  <= pin_irq_q | edge_hit;
            if (|edge_hit) pin_flag_q <= 1'b1;
            // wake point is a count of frame-wrap pulses once armed
            if (frame_wrap && !awake_q && (frame_wake_q || pin_flag_q)) begin
                fcnt_q <= fcnt_q + 8'h01;
                if (fcnt_q == wake_frames_q) req_q <= 1'b1;
            end
            if (req_q && !rx_en_q && !offset_q) offset_q <= 1'b1;
            if (offset_q && !rx_en_q) rx_en_q <= 1'b1;
            if (rx_en_q && pulses_q == 8'h00 && !awake_q) data_oe_c <= 1'b1;
            if (rx_stb && !rx_prev_q) begin
                offset_q <= 1'b0;
                pulses_q <= pulses_q + 8'h01;
                low_q    <= data_line ? 8'h00 : low_q + 8'h01;
                if (pulses_q == 8'h45) data_oe_c <= 1'b0;
            end
            // header search begins; request and enable clear themselves
            if (low_q == 8'h28 && !awake_q) begin
                awake_q <= 1'b1;
                {req_q, rx_en_q, frame_wake_q, pin_flag_q} <= '0;
                {pulses_q, fcnt_q} <= '0;
            end
            // strobe driver off means the link hibernates
            if (!stb_driven) begin
                awake_q <= 1'b0;
                low_q   <= 8'h00;
            end
        end
    end
endmodule

// ---- mwk_host_tb.sv ----
// self-checking bench for the link host: apb master, wire resolution and
// the client model on the far side; each scenario judges its own result.
// assumes mwk_pkg, mwk_host and mwk_client_model are compiled first.
module mwk_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er, frame_wrap, float_q;
    logic        data_out, data_oe, stb_out, stb_oe, link_awake, data_oe_c;
    logic [9:0]  pin_in;
    wire  logic  data_line, stb_line;
    int          errors, num_checks;

    // released wires show a level that changes every cycle, never a hold
    assign data_line = data_oe ? data_out : (data_oe_c ? 1'b1 : float_q);
    assign stb_line  = stb_oe ? stb_out : float_q;
    always @(posedge pclk) float_q <= ~float_q;

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    mwk_host mwk_host_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .data_in(data_line),
        .data_out, .data_oe, .stb_out, .stb_oe, .link_awake);
    mwk_client_model mwk_client_model_inst (.pclk, .presetn, .data_line,
        .stb_line, .stb_driven(stb_oe), .frame_wrap, .pin_in, .data_oe_c);

    // compare and count, hex on mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits for pready however long it takes
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse_frame;
        @(posedge pclk) frame_wrap <= 1'b1;
        @(posedge pclk) frame_wrap <= 1'b0;
    endtask

    // follows one wake sequence from host answer to link awake
    task automatic wake_check;
        int n, settle, hi_n, lo_n;
        logic p;
        n = 0;
        while (data_oe !== 1'b1 && n < 5000) begin @(negedge pclk); n++; end
        chk({data_out, stb_out, stb_oe}, 3'h5);
        settle = 0;
        while (stb_out !== 1'b1 && settle < 100) begin @(negedge pclk); settle++; end
        chk(settle >= 20, 1'b1);
        hi_n = 0; lo_n = 0; p = 1'b0; n = 0;
        while (link_awake !== 1'b1 && n < 5000) begin
            if (stb_out === 1'b1 && p !== 1'b1) begin
                if (data_out === 1'b1) hi_n++; else lo_n++;
            end
            p = stb_out;
            @(negedge pclk);
            n++;
        end
        chk(hi_n, 150);
        chk(lo_n, 50);
        chk(data_oe_c, 1'b0);
        chk(mwk_client_model_inst.awake_q, 1'b1);
    endtask

    task automatic t_reset;
        chk({link_awake, data_oe, stb_oe}, 3'h0);
        chk(mwk_client_model_inst.pin_dir_q, 10'h000);
        chk(mwk_client_model_inst.pin_ien_q, 10'h000);
        chk(mwk_client_model_inst.pin_pol_q, 10'h3FF);
        apb(1'b0, mwk_pkg::STATUS_OFS, 32'h0);
        chk({er, rd[3:0]}, 5'h02);
        apb(1'b0, mwk_pkg::CTRL_OFS, 32'h0);
        chk(rd[2], 1'b1);
        apb(1'b0, 8'h08, 32'h0);                            // unmapped
        chk(er, 1'b1);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_frame_wake;
        mwk_client_model_inst.reg_write(8'h50, 10'h001);
        pulse_frame;
        wake_check;
        chk(mwk_client_model_inst.frame_wake_q, 1'b0);
        apb(1'b0, mwk_pkg::STATUS_OFS, 32'h0);
        chk(rd[3:0], 4'h8);
        $display("test frame wake done");
    endtask

    // shutdown: count strobe falls until the strobe driver is off
    task automatic t_shutdown;
        int falls, d_at, n;
        logic p, bad;
        apb(1'b1, mwk_pkg::CTRL_OFS, 32'h5);
        falls = 0; d_at = 0; n = 0; p = stb_out; bad = 1'b0;
        while (stb_oe === 1'b1 && n < 2000) begin
            @(negedge pclk);
            n++;
            if (p === 1'b1 && stb_out === 1'b0) falls++;
            if (data_oe === 1'b1) begin
                d_at = falls;
                if (data_out !== 1'b0) bad = 1'b1;
            end
            p = stb_out;
        end
        chk(falls, 64);
        chk(d_at >= 16 && d_at <= 48, 1'b1);
        chk(bad, 1'b0);
        chk({data_oe, link_awake}, 2'h0);
        $display("test shutdown done");
    endtask

    task automatic t_pin_wake;
        mwk_client_model_inst.reg_write(8'h69, 10'h008);
        @(posedge pclk) pin_in <= 10'h00C;      // pin 2 is not enabled
        repeat (3) @(posedge pclk);
        chk(mwk_client_model_inst.pin_irq_q, 10'h008);
        pulse_frame;
        wake_check;
        mwk_client_model_inst.reg_write(8'h68, 10'h008);
        chk(mwk_client_model_inst.pin_irq_q, 10'h000);
        @(posedge pclk) pin_in <= 10'h000;
        $display("test pin wake done");
    endtask

    // requests are noted but not answered while auto answer is off
    task automatic t_auto_off;
        apb(1'b1, mwk_pkg::CTRL_OFS, 32'h0);
        // earlier wakes left the sticky flag set; drop it so the read
        // below can only see the request made while answering is off
        apb(1'b1, mwk_pkg::STATUS_OFS, 32'h10);
        mwk_client_model_inst.reg_write(8'h50, 10'h001);
        pulse_frame;
        repeat (300) @(posedge pclk);
        chk(stb_oe, 1'b0);
        apb(1'b0, mwk_pkg::STATUS_OFS, 32'h0);
        chk(rd[4:0], 5'h12);
        apb(1'b1, mwk_pkg::CTRL_OFS, 32'h4);
        wake_check;
        apb(1'b1, mwk_pkg::STATUS_OFS, 32'h10);
        apb(1'b0, mwk_pkg::STATUS_OFS, 32'h0);
        chk(rd[4:0], 5'h08);
        $display("test auto off done");
    endtask

    // host wake command: the client stays quiet, the host still runs
    // settle, 150 high and 50 low strobe cycles before the link is awake
    task automatic t_host_wake;
        int n;
        apb(1'b1, mwk_pkg::CTRL_OFS, 32'h6);
        n = 0;
        while (link_awake !== 1'b1 && n < 3000) begin
            @(negedge pclk);
            n++;
        end
        chk(n > 1600 && n < 1700, 1'b1);
        chk(mwk_client_model_inst.data_oe_c, 1'b0);
        $display("test host wake done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        errors = 0; num_checks = 0; float_q = 1'b0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; pin_in = 10'h000; frame_wrap = 1'b0; presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_frame_wake;
        t_shutdown;
        t_pin_wake;
        t_shutdown;
        t_auto_off;
        t_shutdown;
        t_host_wake;
        summarize;
    end

    // watchdog, well beyond the few thousand cycles the tests take
    initial begin
        #400000;
        errors++;
        summarize;
    end
endmodule
